// [hdl/can_wake_frame_filter_config.v]
// Register store and decode for selective CAN wake-up filtering.
// Assumes a byte-wide register port behind the serial host interface,
// one access per cycle, and received frames presented by the CAN core.
`timescale 1ns/10ps
`include "wake_filter_consts.vh"

// Overview of operation
// - Rate code selects expected CAN bit rate
// - Reserved rate codes 100, 110 mean 500k
// - Identifier byte 0 holds bits 7:0
// - Identifier byte 1 holds bits 15:8
// - Identifier byte 2 holds bits 23:16
// - Identifier byte 3 holds bits 28:24
// - Mask bytes 0,1 mask identifier bits 15:0
// - Mask byte 2 masks identifier bits 23:16
// - Mask byte 3 masks bits 28:24
// - Frame control bit 7 selects identifier format
// - Length code above eight means eight bytes
// - Control bit 6 enables payload comparison
// - Eight payload mask byte registers
module can_wake_frame_filter_config
(
    sys_clk,
    rst_b,
    reg_addr,
    reg_wr_en,
    reg_wdata,
    reg_rd_en,
    reg_rdata,
    frame_valid,
    frame_ext,
    frame_ident,
    frame_dlc,
    frame_data,
    bit_rate_code,
    bit_rate_kbps,
    ident_match,
    wake_match
);
    input  wire        sys_clk;       // System clock, 100 MHz
    input  wire        rst_b;         // Synchronous reset, active low
    input  wire [6:0]  reg_addr;      // Register address
    input  wire        reg_wr_en;     // Write strobe, one cycle
    input  wire [7:0]  reg_wdata;     // Write data
    input  wire        reg_rd_en;     // Read strobe, one cycle
    output reg  [7:0]  reg_rdata;     // Read data, valid next cycle
    input  wire        frame_valid;   // Received frame strobe
    input  wire        frame_ext;     // Received format
    input  wire [28:0] frame_ident;   // Received identifier
    input  wire [3:0]  frame_dlc;     // Received length code
    input  wire [63:0] frame_data;    // Received payload
    output wire [2:0]  bit_rate_code; // Stored rate code
    output reg  [10:0] bit_rate_kbps; // Decoded expected rate
    output wire        ident_match;   // Identifier match pulse
    output wire        wake_match;    // Wake-up frame pulse

    reg  [7:0]  rate_r;               // Rate register, low 3 bits live
    reg  [7:0]  ident_r [0:3];        // Identifier bytes
    reg  [7:0]  ident_mask_r [0:3];   // Identifier mask bytes
    reg  [7:0]  frame_ctrl_r;         // Frame control byte
    reg  [7:0]  payload_mask_r [0:7]; // Payload mask bytes
    reg  [7:0]  rdata_nxt;            // Read mux result
    wire [28:0] cfg_ident;            // Assembled identifier
    wire [28:0] cfg_ident_mask;       // Assembled identifier mask
    wire [63:0] cfg_payload_mask;     // Assembled payload mask
    wire        payload_sel;          // Address hits payload mask block
    wire [2:0]  payload_idx;          // Payload mask byte index

    // Eight payload mask bytes sit in one aligned block of addresses
    assign payload_sel = (reg_addr >= `ADDR_PAYLOAD_MASK0) &&
                         (reg_addr <= `ADDR_PAYLOAD_MASK7);
    assign payload_idx = reg_addr[2:0];

    // Identifier and mask registers; writes to them are byte wide
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1)
        begin : g_ident
            // Top byte keeps only five bits, the rest stays zero
            always @(posedge sys_clk)
            begin
                if (!rst_b)
                begin
                    ident_r[gi]      <= `CFG_RESET;
                    ident_mask_r[gi] <= `CFG_RESET;
                end
                else if (reg_wr_en)
                begin
                    if (reg_addr == `ADDR_IDENT_BYTE0 + gi)
                        ident_r[gi] <= (gi == 3) ?
                            (reg_wdata & `IDENT_TOP_WMASK)
                            : reg_wdata;
                    if (reg_addr == `ADDR_MASK_BYTE0 + gi)
                        ident_mask_r[gi] <= (gi == 3) ?
                            (reg_wdata & `IDENT_TOP_WMASK)
                            : reg_wdata;
                end
            end
        end
        // Payload mask bytes, each fully read-write
        for (gi = 0; gi < 8; gi = gi + 1)
        begin : g_payload
            always @(posedge sys_clk)
            begin
                if (!rst_b)
                    payload_mask_r[gi] <= `CFG_RESET;
                else if (reg_wr_en && payload_sel && payload_idx == gi)
                    payload_mask_r[gi] <= reg_wdata;
            end
            assign cfg_payload_mask[gi*8 +: 8] = payload_mask_r[gi];
        end
    endgenerate

    // Rate and frame control registers
    always @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            rate_r       <= `CFG_RESET;
            frame_ctrl_r <= `CFG_RESET;
        end
        else if (reg_wr_en)
        begin
            if (reg_addr == `ADDR_BIT_RATE)
                rate_r <= reg_wdata & `BIT_RATE_WMASK;
            if (reg_addr == `ADDR_FRAME_CTRL)
                frame_ctrl_r <= reg_wdata & `FRAME_CTRL_WMASK;
        end
    end

    // Byte lanes map straight onto identifier bit positions
    assign cfg_ident = {ident_r[3][4:0], ident_r[2], ident_r[1],
                        ident_r[0]};
    assign cfg_ident_mask = {ident_mask_r[3][4:0], ident_mask_r[2],
                             ident_mask_r[1],
                             ident_mask_r[0]};
    // Rate code leaves straight from the register, no decode delay
    assign bit_rate_code = rate_r[2:0];

    // Rate decode; reserved codes fall through to 500k for now
    always @(posedge sys_clk)
    begin
        if (!rst_b)
            bit_rate_kbps <= `RATE_KBPS_50;
        else
        begin
            case (rate_r[2:0])
                `RATE_CODE_50:   bit_rate_kbps <= `RATE_KBPS_50;
                `RATE_CODE_100:  bit_rate_kbps <= `RATE_KBPS_100;
                `RATE_CODE_125:  bit_rate_kbps <= `RATE_KBPS_125;
                `RATE_CODE_250:  bit_rate_kbps <= `RATE_KBPS_250;
                `RATE_CODE_1000: bit_rate_kbps <= `RATE_KBPS_1000;
                default:         bit_rate_kbps <= `RATE_KBPS_500;
            endcase
        end
    end

    // Read mux; unmapped addresses read as zero
    // Reserved bits need no masking here, they are never stored
    always @*
    begin
        rdata_nxt = 8'h00;
        if (payload_sel)
            rdata_nxt = payload_mask_r[payload_idx];
        else
        begin
            case (reg_addr)
                `ADDR_BIT_RATE:    rdata_nxt = rate_r;
                `ADDR_IDENT_BYTE0: rdata_nxt = ident_r[0];
                `ADDR_IDENT_BYTE1: rdata_nxt = ident_r[1];
                `ADDR_IDENT_BYTE2: rdata_nxt = ident_r[2];
                `ADDR_IDENT_BYTE3: rdata_nxt = ident_r[3];
                `ADDR_MASK_BYTE0:  rdata_nxt = ident_mask_r[0];
                `ADDR_MASK_BYTE1:  rdata_nxt = ident_mask_r[1];
                `ADDR_MASK_BYTE2:  rdata_nxt = ident_mask_r[2];
                `ADDR_MASK_BYTE3:  rdata_nxt = ident_mask_r[3];
                `ADDR_FRAME_CTRL:  rdata_nxt = frame_ctrl_r;
                default:           rdata_nxt = 8'h00;
            endcase
        end
    end

    // Read data is held until the next read
    always @(posedge sys_clk)
    begin
        if (!rst_b)
            reg_rdata <= 8'h00;
        else if (reg_rd_en)
            reg_rdata <= rdata_nxt;
    end

    // Frame comparison against the live configuration
    wake_frame_match u_match
    (
        .sys_clk          (sys_clk),
        .rst_b            (rst_b),
        .frame_valid      (frame_valid),
        .frame_ext        (frame_ext),
        .frame_ident      (frame_ident),
        .frame_dlc        (frame_dlc),
        .frame_data       (frame_data),
        .cfg_ext          (frame_ctrl_r[`FC_FORMAT_BIT]),
        .cfg_ident        (cfg_ident),
        .cfg_ident_mask   (cfg_ident_mask),
        .cfg_payload_en   (frame_ctrl_r[`FC_PAYLOAD_EN_BIT]),
        .cfg_dlc          (frame_ctrl_r[3:0]),
        .cfg_payload_mask (cfg_payload_mask),
        .ident_match      (ident_match),
        .wake_match       (wake_match)
    );
endmodule

// [hdl/wake_filter_consts.vh]
// Constants for the selective CAN wake-up configuration store.
// Assumes byte-wide registers reached by a 7-bit register address.
`ifndef WAKE_FILTER_CONSTS_VH
`define WAKE_FILTER_CONSTS_VH

// Register addresses
`define ADDR_BIT_RATE      7'h26
`define ADDR_IDENT_BYTE0   7'h27
`define ADDR_IDENT_BYTE1   7'h28
`define ADDR_IDENT_BYTE2   7'h29
`define ADDR_IDENT_BYTE3   7'h2A
`define ADDR_MASK_BYTE0    7'h2B
`define ADDR_MASK_BYTE1    7'h2C
`define ADDR_MASK_BYTE2    7'h2D
`define ADDR_MASK_BYTE3    7'h2E
`define ADDR_FRAME_CTRL    7'h2F
`define ADDR_PAYLOAD_MASK0 7'h68
`define ADDR_PAYLOAD_MASK7 7'h6F

// Writable field masks; cleared bits are reserved and read zero
`define BIT_RATE_WMASK     8'h07
`define IDENT_TOP_WMASK    8'h1F
`define FRAME_CTRL_WMASK   8'hCF

// Frame control field positions
`define FC_FORMAT_BIT      7
`define FC_PAYLOAD_EN_BIT  6

// Reset value of every configuration byte
`define CFG_RESET          8'h00

// Rate codes and resulting rates in kbit/s
`define RATE_CODE_50       3'h0
`define RATE_CODE_100      3'h1
`define RATE_CODE_125      3'h2
`define RATE_CODE_250      3'h3
`define RATE_CODE_1000     3'h7
`define RATE_KBPS_50       11'h032
`define RATE_KBPS_100      11'h064
`define RATE_KBPS_125      11'h07D
`define RATE_KBPS_250      11'h0FA
`define RATE_KBPS_500      11'h1F4
`define RATE_KBPS_1000     11'h3E8

// Largest payload length in bytes
`define MAX_PAYLOAD_LEN    4'h8

`endif

// [hdl/wake_frame_match.v]
// Compares one received CAN frame against the stored wake-up filter.
// Assumes the frame fields are stable while frame_valid is high.
`timescale 1ns/10ps
`include "wake_filter_consts.vh"

module wake_frame_match
(
    sys_clk,
    rst_b,
    frame_valid,
    frame_ext,
    frame_ident,
    frame_dlc,
    frame_data,
    cfg_ext,
    cfg_ident,
    cfg_ident_mask,
    cfg_payload_en,
    cfg_dlc,
    cfg_payload_mask,
    ident_match,
    wake_match
);
    input  wire        sys_clk;          // System clock
    input  wire        rst_b;            // Synchronous reset, active low
    input  wire        frame_valid;      // One-cycle frame strobe
    input  wire        frame_ext;        // Received format, 1 = extended
    input  wire [28:0] frame_ident;      // Received identifier
    input  wire [3:0]  frame_dlc;        // Received length code
    input  wire [63:0] frame_data;       // Received payload, byte 0 low
    input  wire        cfg_ext;          // Selected format
    input  wire [28:0] cfg_ident;        // Stored identifier
    input  wire [28:0] cfg_ident_mask;   // 1 = identifier bit ignored
    input  wire        cfg_payload_en;   // Evaluate length and payload
    input  wire [3:0]  cfg_dlc;          // Expected length code
    input  wire [63:0] cfg_payload_mask; // Payload mask, byte 0 low
    output reg         ident_match;      // Identifier matched, pulse
    output reg         wake_match;       // Whole frame qualifies, pulse

    wire [28:0] id_diff;     // Differing bits that are not masked
    wire        id_hit;      // Identifier part matches
    wire [3:0]  exp_len;     // Expected length, clipped to eight
    wire [3:0]  rx_len;      // Received length, clipped to eight
    wire [7:0]  byte_hit;    // Per byte: masked data bit set
    wire        data_hit;    // Payload part matches
    wire        pay_hit;     // Length and payload both match

    // Standard format only uses the top eleven positions
    assign id_diff = (frame_ident ^ cfg_ident) & ~cfg_ident_mask;
    assign id_hit  = (frame_ext == cfg_ext) &&
                     (cfg_ext ? (id_diff == 29'h0)
                              : (id_diff[28:18] == 11'h0));

    // Codes above eight are tolerated as eight bytes
    assign exp_len = (cfg_dlc > `MAX_PAYLOAD_LEN) ? `MAX_PAYLOAD_LEN
                                                  : cfg_dlc;
    assign rx_len  = (frame_dlc > `MAX_PAYLOAD_LEN) ? `MAX_PAYLOAD_LEN
                                                    : frame_dlc;

    // A byte counts only when it lies inside the expected length
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1)
        begin : g_byte
            assign byte_hit[gi] = (gi < exp_len) &&
                (|(frame_data[gi*8 +: 8] & cfg_payload_mask[gi*8 +: 8]));
        end
    endgenerate

    // An empty payload is matched by length alone
    assign data_hit = (exp_len == 4'h0) || (|byte_hit);
    assign pay_hit  = (rx_len == exp_len) && data_hit;

    // Results are registered so that they are clean one-cycle pulses
    always @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            ident_match <= 1'b0;
            wake_match  <= 1'b0;
        end
        else
        begin
            ident_match <= frame_valid && id_hit;
            // Payload ignored unless evaluation is enabled
            wake_match  <= frame_valid && id_hit &&
                           (!cfg_payload_en || pay_hit);
        end
    end
endmodule

// [test/can_frame_source.sv]
// CAN node model: hands received frames to the filter.
// Assumes calls start just after a rising clock edge.
`timescale 1ns/10ps
module can_frame_source
(
    input  wire logic   sys_clk,
    output logic        frame_valid,
    output logic        frame_ext,
    output logic [28:0] frame_ident,
    output logic [3:0]  frame_dlc,
    output logic [63:0] frame_data
);
    // Idle bus at start
    initial
    begin
        frame_valid = 1'b0;
        {frame_ext, frame_ident, frame_dlc, frame_data} = '0;
    end
    // One-cycle strobe; fields flip after it so stale values never match
    task automatic send(input logic [97:0] f);
        {frame_ext, frame_ident, frame_dlc, frame_data} = f;
        frame_valid = 1'b1;
        @(posedge sys_clk);
        #1;
        frame_valid = 1'b0;
        {frame_ext, frame_ident, frame_dlc, frame_data} = ~f;
    endtask
endmodule

// [test/wake_filter_cfg_sva.sv]
// Assertions on the wake filter register store ports.
// Assumes the constants header is on the include path.
`timescale 1ns/10ps
`include "wake_filter_consts.vh"
module wake_filter_cfg_sva
(
    input wire logic        sys_clk,
    input wire logic        rst_b,
    input wire logic [6:0]  reg_addr,
    input wire logic        reg_wr_en,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_rd_en,
    input wire logic [7:0]  reg_rdata,
    input wire logic        frame_valid,
    input wire logic [2:0]  bit_rate_code,
    input wire logic [10:0] bit_rate_kbps,
    input wire logic        ident_match,
    input wire logic        wake_match
);
    logic [7:0] rsv;  // Bits that must read zero here
    logic       full; // Fully writable byte address
    // Unmapped addresses count as all reserved
    always_comb
    begin
        full = reg_addr inside {7'h27, 7'h28, 7'h29, 7'h2B, 7'h2C,
            7'h2D, [7'h68:7'h6F]};
        case (reg_addr)
            `ADDR_BIT_RATE: rsv = 8'hF8;
            `ADDR_IDENT_BYTE3, `ADDR_MASK_BYTE3: rsv = 8'hE0;
            `ADDR_FRAME_CTRL: rsv = 8'h30;
            default: rsv = full ? 8'h00 : 8'hFF;
        endcase
    end
    // Reserved codes fall to 500 kbit/s
    function automatic logic [10:0] rate_of(input logic [2:0] c);
        case (c)
            `RATE_CODE_50: return `RATE_KBPS_50;
            `RATE_CODE_100: return `RATE_KBPS_100;
            `RATE_CODE_125: return `RATE_KBPS_125;
            `RATE_CODE_250: return `RATE_KBPS_250;
            `RATE_CODE_1000: return `RATE_KBPS_1000;
            default: return `RATE_KBPS_500;
        endcase
    endfunction
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);
    // Write then read of the same byte on the next cycle
    sequence s_wr_rd;
        reg_wr_en && full ##1 reg_rd_en && !reg_wr_en && $stable(reg_addr);
    endsequence
    rate_out_a: assert property (reg_wr_en
        && reg_addr == `ADDR_BIT_RATE
        |=> {5'h00, bit_rate_code} == ($past(reg_wdata) & 8'h07))
        else $error("rate code not taken from write");
    rate_decode_a: assert property ($stable(bit_rate_code)
        |-> bit_rate_kbps == rate_of(bit_rate_code))
        else $error("rate decode wrong");
    rate_readback_a: assert property (reg_rd_en
        && reg_addr == `ADDR_BIT_RATE
        |=> reg_rdata == {5'h00, $past(bit_rate_code)})
        else $error("rate readback wrong");
    reserved_zero_a: assert property (reg_rd_en
        |=> (reg_rdata & $past(rsv)) == 8'h00)
        else $error("reserved bits read nonzero");
    byte_readback_a: assert property (s_wr_rd
        |=> reg_rdata == $past(reg_wdata, 2))
        else $error("byte readback wrong");
    rdata_hold_a: assert property (!reg_rd_en |=> $stable(reg_rdata))
        else $error("read data moved without read");
    match_pulse_a: assert property (!frame_valid
        |=> !ident_match && !wake_match)
        else $error("match without frame");
    wake_needs_id_a: assert property (wake_match |-> ident_match)
        else $error("wake without identifier match");
endmodule
bind can_wake_frame_filter_config wake_filter_cfg_sva u_wake_filter_cfg_sva
(
    .sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en),
    .reg_rdata(reg_rdata), .frame_valid(frame_valid),
    .bit_rate_code(bit_rate_code), .bit_rate_kbps(bit_rate_kbps),
    .ident_match(ident_match), .wake_match(wake_match)
);

// [test/can_wake_frame_filter_config_tb.sv]
// Self-checking bench for the wake filter register store.
// Assumes the frame source model and checker are compiled first.
`timescale 1ns/10ps
`include "wake_filter_consts.vh"
module can_wake_frame_filter_config_tb;
    localparam logic [28:0] ID = 29'h1ABCDE5A; // Filter identifier
    localparam logic [63:0] D7 = 64'h0100000000000000; // Byte 7 bit 0
    logic        sys_clk;
    logic        rst_b;
    logic [6:0]  reg_addr = 7'h00;
    logic        reg_wr_en;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_rd_en;
    wire  [7:0]  reg_rdata;
    wire         fv, fe;
    wire  [28:0] fi;
    wire  [3:0]  fd;
    wire  [63:0] fdat;
    wire  [2:0]  bit_rate_code;
    wire  [10:0] bit_rate_kbps;
    wire         ident_match, wake_match;
    int          failures = 0;
    int          check_count = 0;
    int          cycles = 0;
    can_wake_frame_filter_config u_can_wake_frame_filter_config
    (
        .sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata),
        .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata),
        .frame_valid(fv), .frame_ext(fe), .frame_ident(fi),
        .frame_dlc(fd), .frame_data(fdat),
        .bit_rate_code(bit_rate_code), .bit_rate_kbps(bit_rate_kbps),
        .ident_match(ident_match), .wake_match(wake_match)
    );
    can_frame_source u_can_frame_source
    (
        .sys_clk(sys_clk), .frame_valid(fv), .frame_ext(fe),
        .frame_ident(fi), .frame_dlc(fd), .frame_data(fdat)
    );
    // 100 MHz clock
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // Hang guard; the run needs well under a thousand cycles
    always @(posedge sys_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            failures = failures + 1;
            complete_run();
        end
    end
    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic check(input logic [63:0] s, input logic [63:0] e);
        check_count = check_count + 1;
        if (s !== e)
        begin
            failures = failures + 1;
            $display("FAIL at %0t: seen %0h expected %0h", $time, s, e);
        end
    endtask
    // Strobes stay up until the next task sets them, so no double drive
    task automatic bus_idle;
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
    endtask
    task automatic reg_write(input logic [6:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_rd_en = 1'b0;
        reg_wr_en = 1'b1;
        @(posedge sys_clk);
        #1;
    endtask
    task automatic wr_rd(input logic [6:0] a, input logic [7:0] d, e);
        reg_write(a, d);
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b1;
        @(posedge sys_clk);
        #1;
        check(reg_rdata, e);
    endtask
    // Send one frame and judge both match pulses in their cycle
    task automatic fc(input logic [97:0] f, input logic [1:0] e);
        bus_idle();
        u_can_frame_source.send(f);
        check({ident_match, wake_match}, e);
    endtask
    task automatic set_filter(input logic [31:0] i, k, input logic [7:0] c);
        for (int b = 0; b < 4; b++)
        begin
            reg_write(`ADDR_IDENT_BYTE0 + b[6:0], i[8*b +: 8]);
            reg_write(`ADDR_MASK_BYTE0 + b[6:0], k[8*b +: 8]);
        end
        reg_write(`ADDR_FRAME_CTRL, c);
    endtask
    task automatic do_reset;
        bus_idle();
        rst_b = 1'b0;
        repeat (10) @(posedge sys_clk);
        #1;
        rst_b = 1'b1;
    endtask
    // Control registers read zero after reset
    task automatic t_reset_values;
        check(bit_rate_kbps, `RATE_KBPS_50);
        for (int a = 'h26; a < 'h30; a++)
            wr_rd(7'h7F, 8'hFF, 8'h00);
        for (int a = 'h26; a < 'h30; a++)
        begin
            reg_wr_en = 1'b0;
            reg_addr = a[6:0];
            reg_rd_en = 1'b1;
            @(posedge sys_clk);
            #1;
            check(reg_rdata, `CFG_RESET);
        end
    endtask
    // Every rate code, reserved bits written high
    task automatic t_rate_codes;
        logic [10:0] tab [8];
        tab = '{`RATE_KBPS_50, `RATE_KBPS_100, `RATE_KBPS_125,
            `RATE_KBPS_250, `RATE_KBPS_500, `RATE_KBPS_500,
            `RATE_KBPS_500, `RATE_KBPS_1000};
        for (int c = 0; c < 8; c++)
        begin
            wr_rd(`ADDR_BIT_RATE, {5'h1F, c[2:0]}, {5'h00, c[2:0]});
            check(bit_rate_code, c[2:0]);
            check(bit_rate_kbps, tab[c]);
        end
    endtask
    task automatic t_regs;
        wr_rd(`ADDR_IDENT_BYTE1, 8'hC3, 8'hC3);
        wr_rd(`ADDR_IDENT_BYTE3, 8'hFF, 8'h1F);
        wr_rd(`ADDR_MASK_BYTE0, 8'h3C, 8'h3C);
        wr_rd(`ADDR_MASK_BYTE2, 8'h69, 8'h69);
        wr_rd(`ADDR_MASK_BYTE3, 8'hFF, 8'h1F);
        wr_rd(`ADDR_FRAME_CTRL, 8'hFF, 8'hCF);
        for (int a = 'h68; a < 'h70; a++)
            wr_rd(a[6:0], a[7:0] ^ 8'hA5, a[7:0] ^ 8'hA5);
    endtask
    task automatic t_ident;
        set_filter({3'h0, ID}, 32'h0, 8'h80);
        fc({1'b1, ID, 4'h0, 64'h0}, 2'b11);
        fc({1'b1, ID ^ 29'h1, 4'h0, 64'h0}, 2'b00);
        fc({1'b1, ID ^ 29'h10000000, 4'h0, 64'h0}, 2'b00);
        fc({1'b0, ID, 4'h0, 64'h0}, 2'b00);
        set_filter({3'h0, ID}, 32'h10010001, 8'h80);
        fc({1'b1, ID ^ 29'h10010001, 4'h0, 64'h0}, 2'b11);
        fc({1'b1, ID ^ 29'h40, 4'h0, 64'h0}, 2'b00);
        set_filter({3'h0, ID}, 32'h0, 8'h00);
        fc({1'b0, 29'h1ABC0000, 4'h0, 64'h0}, 2'b11);
        fc({1'b0, 29'h1AB80000, 4'h0, 64'h0}, 2'b00);
        fc({1'b1, ID, 4'h0, 64'h0}, 2'b00);
    endtask
    // Length code ten expects eight bytes
    task automatic t_payload;
        set_filter({3'h0, ID}, 32'h0, 8'hCA);
        reg_write(`ADDR_PAYLOAD_MASK7, 8'h01);
        fc({1'b1, ID, 4'h8, D7}, 2'b11);
        fc({1'b1, ID, 4'hF, D7}, 2'b11);
        fc({1'b1, ID, 4'h7, D7}, 2'b10);
        fc({1'b1, ID, 4'h8, D7 << 1}, 2'b10);
        reg_write(`ADDR_FRAME_CTRL, 8'h87);
        fc({1'b1, ID, 4'h8, 64'h0}, 2'b11);
        // Empty expected payload matches on length alone
        reg_write(`ADDR_FRAME_CTRL, 8'hC0);
        fc({1'b1, ID, 4'h0, 64'h0}, 2'b11);
        fc({1'b1, ID, 4'h1, D7}, 2'b10);
    endtask
    // Main sequence, with a second reset in mid-run
    initial
    begin
        do_reset();
        t_reset_values();
        t_rate_codes();
        t_regs();
        t_ident();
        t_payload();
        do_reset();
        t_reset_values();
        complete_run();
    end
endmodule
